// *** rtl/sai_adc_ctrl.sv ***
// Command decoder, scan engine and serial link of the converter
//
// Functional notes
// - One MSB-first byte, leading marker bits route
// - Conversion: channel bits 6-3, scan 2-1
// - Low channel bits pick input 0-3
// - Scan modes: low range, high range, repeat, once
// - Start by command or convert-start low pulse
// - No conversion on start-pin channel in command-start modes
// - Setup: clock mode 5-4, reference 3-2
// - Clock mode picks internal or serial timing
// - Clock mode upper bit set at power-up
// - Reference modes; wake delay when auto-off
// - Averaging: enable, count, repeat fields
// - Average 1, 4, 8, 16 or 32 conversions
// - Averaging all scans, never serial clock mode
// - Repeat scan returns 4, 8, 12, 16 results
// - Reset command type in bit 3
// - Type 1 clears FIFO, 0 restores defaults
// - Link active on chip select; output floats
// - Input data taken on serial clock rise
// - Output data shifted on serial clock fall
// - End of conversion low marks valid data
// - Four inputs, ten-bit results
module sai_adc_ctrl #(
	parameter int WAKE_CYC = sai_pkg::WAKE_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	input wire logic i_convert_start_n,
	input wire logic [sai_pkg::RES_W-1:0] i_analog_code,
	output logic [1:0] o_analog_sel,
	output logic o_miso,
	output logic o_miso_oe,
	output logic o_eoc_n
);
	// ----------------------------------------------------------------
	// Reset release and pin sampling
	// ----------------------------------------------------------------
	logic [1:0] rst_q;
	wire rst_n = rst_q[1];
	logic [3:0] pin_q;
	logic sclk_d, cs_d, cnv_d;
	// Reset leaves through two flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	sai_sync #(.W(4), .RST_VAL(4'h5)) u_sync (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_d({i_sclk, i_cs_n, i_mosi, i_convert_start_n}),
		.o_q(pin_q)
	);
	wire sclk_s = pin_q[3];
	wire cs_s = pin_q[2];
	wire mosi_s = pin_q[1];
	wire cnv_s = pin_q[0];
	// Previous pin levels for edge finding
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
			cnv_d <= 1'b1;
		end else if (i_ce) begin
			sclk_d <= sclk_s;
			cs_d <= cs_s;
			cnv_d <= cnv_s;
		end
	end
	// Clock edges count only while selected
	wire sclk_rise = sclk_s & ~sclk_d & ~cs_s;
	wire sclk_fall = ~sclk_s & sclk_d & ~cs_s;
	wire cs_fall = ~cs_s & cs_d;
	wire cnv_fall = ~cnv_s & cnv_d;
	// ----------------------------------------------------------------
	// Command receiver
	// ----------------------------------------------------------------
	logic [6:0] rx_sr;
	logic [2:0] bit_cnt;
	// Shift on rising clock, restart when deselected
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_sr <= 7'h00;
			bit_cnt <= 3'h0;
		end else if (i_ce) begin
			if (cs_s) begin
				bit_cnt <= 3'h0;
			end else if (sclk_rise) begin
				rx_sr <= {rx_sr[5:0], mosi_s};
				bit_cnt <= bit_cnt + 3'h1;
			end
		end
	end
	// Byte complete on eighth rise, routed by marker
	wire cmd_stb = sclk_rise & (bit_cnt == 3'h7);
	wire [7:0] cmd = {rx_sr, mosi_s};
	wire is_conv = cmd[sai_pkg::MARK_CONV];
	wire is_setup = cmd[7:6] == 2'h1;
	wire is_avg = cmd[7:5] == 3'h1;
	wire is_rst = cmd[7:4] == 4'h1;
	wire wr_conv = cmd_stb & is_conv;
	wire wr_setup = cmd_stb & is_setup;
	wire wr_avg = cmd_stb & is_avg;
	wire wr_rst = cmd_stb & is_rst;
	wire soft_rst = wr_rst & ~cmd[sai_pkg::RST_TYPE_BIT];
	wire fifo_clr = wr_rst & cmd[sai_pkg::RST_TYPE_BIT];
	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [3:0] chan_sel;
	logic [1:0] scan_sel;
	logic [1:0] clk_mode;
	logic [1:0] ref_mode;
	logic avg_enable;
	logic [1:0] avg_count;
	logic [1:0] repeat_count;
	// Command writes; full reset restores defaults
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_sel <= sai_pkg::CHAN_RST;
			scan_sel <= sai_pkg::SCAN_RST;
			clk_mode <= sai_pkg::CLK_MODE_RST;
			ref_mode <= sai_pkg::REF_MODE_RST;
			avg_enable <= 1'b0;
			avg_count <= sai_pkg::AVG_CNT_RST;
			repeat_count <= sai_pkg::REP_CNT_RST;
		end else if (i_ce) begin
			if (soft_rst) begin
				chan_sel <= sai_pkg::CHAN_RST;
				scan_sel <= sai_pkg::SCAN_RST;
				clk_mode <= sai_pkg::CLK_MODE_RST;
				ref_mode <= sai_pkg::REF_MODE_RST;
				avg_enable <= 1'b0;
				avg_count <= sai_pkg::AVG_CNT_RST;
				repeat_count <= sai_pkg::REP_CNT_RST;
			end
			if (wr_conv) begin
				chan_sel <= cmd[sai_pkg::CONV_CH_HI:sai_pkg::CONV_CH_LO];
				scan_sel <= cmd[sai_pkg::CONV_SCAN_HI:sai_pkg::CONV_SCAN_LO];
			end
			if (wr_setup) begin
				clk_mode <= cmd[sai_pkg::SET_CLK_HI:sai_pkg::SET_CLK_LO];
				ref_mode <= cmd[sai_pkg::SET_REF_HI:sai_pkg::SET_REF_LO];
			end
			if (wr_avg) begin
				avg_enable <= cmd[sai_pkg::AVG_EN_BIT];
				avg_count <= cmd[sai_pkg::AVG_N_HI:sai_pkg::AVG_N_LO];
				repeat_count <= cmd[sai_pkg::AVG_REP_HI:sai_pkg::AVG_REP_LO];
			end
		end
	end
	// ----------------------------------------------------------------
	// Scan engine
	// ----------------------------------------------------------------
	sai_pkg::sai_state_e state;
	logic start_pend;
	logic scan_done;
	logic [1:0] cur_ch;
	logic [4:0] res_left;
	logic [5:0] conv_cnt;
	logic [14:0] sum;
	logic [13:0] cyc_cnt;
	logic fifo_ready;
	logic fifo_valid;
	logic [sai_pkg::RES_W-1:0] fifo_dout;
	// Request source follows clock mode
	wire req = clk_mode[1] ? wr_conv : cnv_fall;
	wire start_req = req & (state == sai_pkg::ST_IDLE) & ~soft_rst;
	wire [1:0] chan_n = chan_sel[1:0];
	wire [1:0] first_ch = (scan_sel == sai_pkg::SCAN_LOW) ? 2'h0 : chan_n;
	wire [1:0] last_ch = (scan_sel == sai_pkg::SCAN_HIGH) ?
		sai_pkg::LAST_CH : chan_n;
	wire [4:0] rep_total = {1'b0, repeat_count, 2'h0} + 5'h4;
	wire [4:0] first_left = (scan_sel == sai_pkg::SCAN_REPEAT) ?
		rep_total : 5'h1;
	wire ext_clk = clk_mode == sai_pkg::CLK_EXT;
	wire avg_on = avg_enable & ~ext_clk;
	wire [5:0] n_conv = avg_on ? (6'h04 << avg_count) : 6'h01;
	wire [2:0] avg_shift = avg_on ? {1'b0, avg_count} + 3'h2 : 3'h0;
	wire [14:0] avg_res = sum >> avg_shift;
	wire skip_ch = sai_pkg::CONVERT_START_N_SHARED & clk_mode[1] &
		(cur_ch == sai_pkg::CONVERT_START_N_CH);
	wire int_tick = cyc_cnt == 14'(sai_pkg::CONV_CYC - 1);
	wire ext_tick = sclk_rise &
		(cyc_cnt[4:0] == sai_pkg::SCLK_PER_CONV - 5'h1);
	wire conv_tick = ext_clk ? ext_tick : int_tick;
	wire cyc_step = ext_clk ? sclk_rise : 1'b1;
	wire wake_end = cyc_cnt == 14'(WAKE_CYC - 1);
	wire push_valid = (state == sai_pkg::ST_PUSH) & ~skip_ch;
	wire push_go = (state == sai_pkg::ST_PUSH) & (fifo_ready | skip_ch);
	wire more_res = res_left > 5'h1;
	wire more_ch = cur_ch != last_ch;
	// Scan sequencing, stalls while the FIFO is full
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= sai_pkg::ST_IDLE;
			start_pend <= 1'b0;
			scan_done <= 1'b0;
			cur_ch <= 2'h0;
			res_left <= 5'h0;
			conv_cnt <= 6'h00;
			sum <= 15'h0000;
			cyc_cnt <= 14'h0000;
		end else if (i_ce) begin
			start_pend <= start_req;
			scan_done <= 1'b0;
			if (soft_rst) begin
				state <= sai_pkg::ST_IDLE;
				start_pend <= 1'b0;
			end else begin
				unique case (state)
					sai_pkg::ST_IDLE: begin
						cur_ch <= first_ch;
						res_left <= first_left;
						conv_cnt <= 6'h00;
						sum <= 15'h0000;
						cyc_cnt <= 14'h0000;
						if (start_pend) begin
							// Auto-off reference wakes first
							state <= (ref_mode == sai_pkg::REF_INT_AUTO) ?
								sai_pkg::ST_WAKE : sai_pkg::ST_CONV;
						end
					end
					sai_pkg::ST_WAKE: begin
						cyc_cnt <= cyc_cnt + 14'h0001;
						if (wake_end) begin
							cyc_cnt <= 14'h0000;
							state <= sai_pkg::ST_CONV;
						end
					end
					sai_pkg::ST_CONV: begin
						if (skip_ch) begin
							state <= sai_pkg::ST_PUSH;
						end else if (conv_tick) begin
							sum <= sum + 15'(i_analog_code);
							conv_cnt <= conv_cnt + 6'h01;
							cyc_cnt <= 14'h0000;
							if (conv_cnt == n_conv - 6'h01) begin
								state <= sai_pkg::ST_PUSH;
							end
						end else if (cyc_step) begin
							cyc_cnt <= cyc_cnt + 14'h0001;
						end
					end
					sai_pkg::ST_PUSH: begin
						if (push_go) begin
							sum <= 15'h0000;
							conv_cnt <= 6'h00;
							if (more_res) begin
								res_left <= res_left - 5'h1;
								state <= sai_pkg::ST_CONV;
							end else if (more_ch) begin
								cur_ch <= cur_ch + 2'h1;
								res_left <= 5'h1;
								state <= sai_pkg::ST_CONV;
							end else begin
								scan_done <= 1'b1;
								state <= sai_pkg::ST_IDLE;
							end
						end
					end
				endcase
			end
		end
	end
	// ----------------------------------------------------------------
	// Result buffer
	// ----------------------------------------------------------------
	logic tx_load, tx_pop, tx_next, tx_held;
	sai_fifo #(.W(sai_pkg::RES_W), .D(sai_pkg::FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_flush(fifo_clr | soft_rst),
		.i_valid(push_valid),
		.o_ready(fifo_ready),
		.i_data(avg_res[sai_pkg::RES_W-1:0]),
		.o_valid(fifo_valid),
		.i_ready(tx_pop),
		.o_data(fifo_dout)
	);
	// ----------------------------------------------------------------
	// Serial output and status
	// ----------------------------------------------------------------
	logic [sai_pkg::TX_W-1:0] tx_sr;
	logic [3:0] tx_cnt;
	// Head shown at select; it leaves the FIFO only once fully sent
	wire tx_wrap = sclk_fall & (tx_cnt == 4'hf);
	assign tx_pop = tx_wrap & tx_held;
	assign tx_load = cs_fall | tx_next;
	wire [sai_pkg::TX_W-1:0] tx_word = fifo_valid ?
		{fifo_dout, sai_pkg::TX_PAD} : 16'h0000;
	// Shift on falling clock, MSB first
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sr <= 16'h0000;
			tx_cnt <= 4'h0;
			tx_next <= 1'b0;
			tx_held <= 1'b0;
			o_miso_oe <= 1'b0;
			o_eoc_n <= 1'b1;
			o_analog_sel <= 2'h0;
		end else if (i_ce) begin
			o_miso_oe <= ~cs_s;
			o_analog_sel <= cur_ch;
			tx_next <= tx_wrap;
			tx_held <= (tx_load ? fifo_valid : tx_held) &
				~(fifo_clr | soft_rst);
			if (tx_load) begin
				tx_sr <= tx_word;
				tx_cnt <= 4'h0;
			end else if (sclk_fall) begin
				tx_sr <= {tx_sr[14:0], 1'b0};
				tx_cnt <= tx_cnt + 4'h1;
			end
			// Done wins over a clear in the same cycle
			if (scan_done) begin
				o_eoc_n <= 1'b0;
			end else if (start_pend | soft_rst) begin
				o_eoc_n <= 1'b1;
			end
		end
	end
	assign o_miso = tx_sr[sai_pkg::TX_W-1];
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n || !i_ce);
	chk_miso_float: assert property (cs_s |=> !o_miso_oe)
		else $error("data output driven while deselected");
	chk_eoc_done: assert property (scan_done |=> !o_eoc_n)
		else $error("end of conversion not low after scan");
	chk_soft_default: assert property (soft_rst |=>
		(clk_mode == 2'h2) && !avg_enable && (state == sai_pkg::ST_IDLE))
		else $error("full reset did not restore defaults");
	chk_fifo_clear: assert property (fifo_clr ##1 !push_valid |->
		##1 !fifo_valid)
		else $error("FIFO not emptied by reset command");
	chk_rx_sample: assert property (sclk_rise |=>
		rx_sr[0] == $past(mosi_s))
		else $error("input bit not taken on rising clock");
	chk_tx_shift: assert property (sclk_fall && !tx_load |=>
		tx_sr[15] == $past(tx_sr[14]))
		else $error("output bit not shifted on falling clock");
	chk_cmd_start: assert property (wr_conv && clk_mode[1] &&
		state == sai_pkg::ST_IDLE |=> ##1 state != sai_pkg::ST_IDLE)
		else $error("conversion command did not start a scan");
	chk_rep_count: assert property (state == sai_pkg::ST_IDLE &&
		scan_sel == sai_pkg::SCAN_REPEAT |=>
		res_left == $past(rep_total))
		else $error("repeat count wrong");
	chk_ext_noavg: assert property (state == sai_pkg::ST_CONV &&
		ext_clk && conv_tick && !skip_ch |=> state == sai_pkg::ST_PUSH)
		else $error("averaging active in serial clock mode");
endmodule // sai_adc_ctrl

// *** rtl/sai_pkg.sv ***
// Constants, field layout and types of the serial converter control block
package sai_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int CMD_W = 8;
	localparam int RES_W = 10;
	localparam int NCH = 4;
	localparam int FIFO_DEPTH = 32;
	localparam int TX_W = 16;
	localparam logic [5:0] TX_PAD = 6'h00;
	// ----------------------------------------------------------------
	// Command byte layout
	// ----------------------------------------------------------------
	localparam int MARK_CONV = 7;
	localparam int MARK_SETUP = 6;
	localparam int MARK_AVG = 5;
	localparam int MARK_RST = 4;
	localparam int CONV_CH_HI = 6;
	localparam int CONV_CH_LO = 3;
	localparam int CONV_SCAN_HI = 2;
	localparam int CONV_SCAN_LO = 1;
	localparam int SET_CLK_HI = 5;
	localparam int SET_CLK_LO = 4;
	localparam int SET_REF_HI = 3;
	localparam int SET_REF_LO = 2;
	localparam int AVG_EN_BIT = 4;
	localparam int AVG_N_HI = 3;
	localparam int AVG_N_LO = 2;
	localparam int AVG_REP_HI = 1;
	localparam int AVG_REP_LO = 0;
	localparam int RST_TYPE_BIT = 3;
	// ----------------------------------------------------------------
	// Mode codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] SCAN_LOW = 2'h0;
	localparam logic [1:0] SCAN_HIGH = 2'h1;
	localparam logic [1:0] SCAN_REPEAT = 2'h2;
	localparam logic [1:0] SCAN_ONCE = 2'h3;
	localparam logic [1:0] CLK_EXT = 2'h3;
	localparam logic [1:0] REF_INT_AUTO = 2'h0;
	localparam logic [1:0] CLK_MODE_RST = 2'h2;
	localparam logic [1:0] REF_MODE_RST = 2'h0;
	localparam logic [3:0] CHAN_RST = 4'h0;
	localparam logic [1:0] SCAN_RST = 2'h0;
	localparam logic [1:0] AVG_CNT_RST = 2'h0;
	localparam logic [1:0] REP_CNT_RST = 2'h0;
	localparam logic CONVERT_START_N_SHARED = 1'b0;
	localparam logic [1:0] CONVERT_START_N_CH = 2'h3;
	localparam logic [1:0] LAST_CH = 2'h3;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int T_CONV_NS = 3000;
	localparam int CONV_CYC = (T_CONV_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WAKE_NS = 65000;
	localparam int WAKE_CYC = (T_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [4:0] SCLK_PER_CONV = 5'h10;
	typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_CONV, ST_PUSH} sai_state_e;
endpackage

// *** rtl/sai_sync.sv ***
// Two flip-flop synchroniser for pin inputs
module sai_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta;
	// Second stage alone is visible outside
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= RST_VAL;
			o_q <= RST_VAL;
		end else if (i_ce) begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule // sai_sync

// *** rtl/sai_fifo.sv ***
// Result FIFO with valid and ready on both sides
module sai_fifo #(
	parameter int W = 10,
	parameter int D = 32
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_flush,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire do_wr = i_valid & o_ready;
	wire do_rd = o_valid & i_ready;
	// Full when pointers differ only in wrap bit
	assign o_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign o_valid = wr_ptr != rd_ptr;
	assign o_data = mem[rd_ptr[AW-1:0]];
	// Storage
	always_ff @(posedge i_clk) begin
		if (i_ce && do_wr) begin
			mem[wr_ptr[AW-1:0]] <= i_data;
		end
	end
	// Pointers
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else if (i_ce) begin
			if (i_flush) begin
				wr_ptr <= '0;
				rd_ptr <= '0;
			end else begin
				wr_ptr <= wr_ptr + (AW + 1)'(do_wr);
				rd_ptr <= rd_ptr + (AW + 1)'(do_rd);
			end
		end
	end
endmodule // sai_fifo

// *** testbench/sai_host_model.sv ***
// Host side of the serial link: frames command bytes and reads result words
module sai_host_model #(
	parameter int HALF = 16
) (
	input wire logic i_clk,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi,
	input wire logic i_miso,
	input wire logic i_miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// Idle levels
	// ----------------------------------------------------------------
	// Link clock stands still low and select stays high between frames
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// ----------------------------------------------------------------
	// One frame of nb bits, full duplex
	// ----------------------------------------------------------------
	// Data set while clock low, read back midway through the high phase
	task automatic xfer(input logic [15:0] tx, input int nb,
		output logic [15:0] rx, output logic oe_ok);
		logic [15:0] sh;
		sh = tx << (16 - nb);
		rx = '0;
		oe_ok = 1'b1;
		repeat (4) @(posedge i_clk);
		o_cs_n <= 1'b0;
		repeat (HALF) @(posedge i_clk);
		for (int i = 0; i < nb; i++) begin
			o_mosi <= sh[15];
			sh = sh << 1;
			repeat (HALF) @(posedge i_clk);
			o_sclk <= 1'b1;
			repeat (HALF / 2) @(posedge i_clk);
			rx = {rx[14:0], i_miso};
			oe_ok = oe_ok & i_miso_oe;
			repeat (HALF / 2) @(posedge i_clk);
			o_sclk <= 1'b0;
		end
		repeat (HALF) @(posedge i_clk);
		o_cs_n <= 1'b1;
		o_mosi <= ~o_mosi; // Released line must not keep its last level
	endtask
endmodule // sai_host_model

// *** testbench/sai_adc_ctrl_tb.sv ***
// Self-checking bench of the converter control block against a queue model
module sai_adc_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int TMO = 98000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cvs_n = 1'b1;
	logic sclk, cs_n, mosi, miso, miso_oe, eoc_n;
	logic [1:0] sel;
	logic [9:0] code = 10'h000;
	logic [9:0] ana [4];
	logic [31:0] seed = 32'hc991_79ef;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int m_clk, m_avg_en, m_avg_cnt, m_rep;

	initial begin
		forever #2.5 clk = ~clk;
	end

	sai_adc_ctrl #(.WAKE_CYC(20)) i_sai_adc_ctrl (.i_clk(clk),
		.i_rst_n(rst_n), .i_ce(1'b1), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_mosi(mosi), .i_convert_start_n(cvs_n), .i_analog_code(code),
		.o_analog_sel(sel), .o_miso(miso), .o_miso_oe(miso_oe),
		.o_eoc_n(eoc_n));

	sai_host_model i_sai_host_model (.i_clk(clk), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe));

	// Analog source answers the channel being converted
	always @(posedge clk) begin
		code <= ana[sel];
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic finish_test();
		if (err_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == TMO) begin
			err_count++;
			finish_test();
		end
	end

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk_word(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_num(input string what, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			err_count++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Conversion byte with random don't-care and upper channel bits
	function automatic logic [7:0] conv_cmd(input logic [1:0] ch,
		input logic [1:0] sm);
		logic [31:0] r;
		r = rnd();
		return {1'b1, r[1:0], ch, sm, r[2]};
	endfunction

	// Model of the configuration registers
	task automatic model_cmd(input logic [7:0] c);
		if (c[7:6] == 2'b01) begin
			m_clk = c[5:4];
		end else if (c[7:5] == 3'b001) begin
			m_avg_en = c[4];
			m_avg_cnt = c[3:2];
			m_rep = c[1:0];
		end else if (c[7:4] == 4'b0001 && !c[3]) begin
			m_clk = 2;
			m_avg_en = 0;
			m_avg_cnt = 0;
			m_rep = 0;
		end
	endtask

	task automatic send(input logic [7:0] c);
		logic [15:0] rx;
		logic ok;
		i_sai_host_model.xfer({8'h00, c}, 8, rx, ok);
		model_cmd(c);
	endtask

	task automatic read_word(input logic [15:0] exp);
		logic [15:0] rx;
		logic ok;
		i_sai_host_model.xfer(16'h0000, 16, rx, ok);
		chk_word("result word", exp, rx);
		chk_word("drive enable", 16'h0001, {15'h0000, ok});
		repeat (6) @(posedge clk);
		chk_word("idle enable", 16'h0000, {15'h0000, miso_oe});
	endtask

	// Request a scan, time it in conversions, then read nread words
	task automatic do_scan(input logic [7:0] c, input int nread);
		int q[$];
		int nav;
		int cnt;
		logic [15:0] exp;
		for (int k = 0; k < 4; k++) begin
			ana[k] = 10'(rnd());
		end
		case (c[2:1])
			2'h0: for (int k = 0; k <= c[4:3]; k++) q.push_back(k);
			2'h1: for (int k = c[4:3]; k < 4; k++) q.push_back(k);
			2'h2: repeat (4 * (m_rep + 1)) q.push_back(c[4:3]);
			default: q.push_back(c[4:3]);
		endcase
		nav = (m_avg_en != 0 && m_clk != 3) ? (4 << m_avg_cnt) : 1;
		send(c);
		if (m_clk < 2) begin
			repeat (200) @(posedge clk);
			chk_word("eoc before pin", 16'h0000, {15'h0, eoc_n});
			cvs_n <= 1'b0;
			repeat (8) @(posedge clk);
			cvs_n <= 1'b1;
		end
		cnt = 0;
		while (eoc_n !== 1'b1 && cnt < 100) begin
			@(posedge clk);
			cnt++;
		end
		cnt = 0;
		while (eoc_n !== 1'b0 && cnt < 40000) begin
			@(posedge clk);
			cnt++;
		end
		chk_num("conversions", q.size() * nav, (cnt + 300) / 600);
		for (int k = 0; k < nread; k++) begin
			exp = '0;
			if (q.size() > 0) begin
				exp = {ana[q.pop_front()], sai_pkg::TX_PAD};
			end
			read_word(exp);
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] r;
		for (int k = 0; k < 4; k++) begin
			ana[k] = 10'h000;
		end
		model_cmd(8'h10);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		chk_word("eoc after reset", 16'h0001, {15'h0, eoc_n});
		// Scan modes, default clock mode and auto-off reference
		do_scan(conv_cmd(2'h2, 2'h0), 4);
		r = rnd();
		send({2'b01, 2'h2, 2'h2, r[1:0]});
		do_scan(conv_cmd(2'h1, 2'h1), 4);
		do_scan(conv_cmd(2'h3, 2'h3), 2);
		// Every averaging count on a single result
		for (int a = 0; a < 4; a++) begin
			r = rnd();
			send({3'b001, 1'b1, a[1:0], r[1:0]});
			do_scan(conv_cmd(r[3:2], 2'h3), 1);
		end
		// Every repeat count, then clear the filled result store
		for (int p = 0; p < 4; p++) begin
			r = rnd();
			send({3'b001, 1'b0, r[1:0], p[1:0]});
			do_scan(conv_cmd(r[3:2], 2'h2), 1);
			send({5'b0001_1, r[6:4]});
			read_word(16'h0000);
		end
		// Pin-started scans in both pin clock modes
		for (int m = 0; m < 2; m++) begin
			send({2'b01, m[1:0], 2'h2, 2'h0});
			do_scan(conv_cmd(2'h1, 2'h3), 1);
		end
		// Serial-timed mode ignores averaging
		send({2'b01, 2'h3, 2'h2, 2'h0});
		send({3'b001, 1'b1, 2'h3, 2'h0});
		ana[2] = 10'(rnd());
		send(conv_cmd(2'h2, 2'h3));
		read_word(16'h0000);
		repeat (100) @(posedge clk);
		chk_word("eoc serial timed", 16'h0000, {15'h0, eoc_n});
		read_word({ana[2], sai_pkg::TX_PAD});
		// Full reset restores defaults
		send({5'b0001_0, 3'h5});
		repeat (8) @(posedge clk);
		chk_word("eoc after full reset", 16'h0001, {15'h0, eoc_n});
		do_scan(conv_cmd(2'h0, 2'h3), 2);
		finish_test();
	end
endmodule // sai_adc_ctrl_tb
